// ### src/quadrature_decoder_extensions.sv
`timescale 1ns/1ps
module quadrature_decoder_extensions (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // APB slave port.
    input wire qdec_pkg::apb_req_t i_apb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Channel I/O lines; A0, B0 are the phases, A1 the index, or B0 when BMR_INDEX_ON_PHASE_B is set.
    input wire logic [2:0] i_io_a,
    input wire logic [2:0] i_io_b,
    output logic [2:0] o_io_a,
    output logic [2:0] o_io_b,
    // Fault output.
    output logic o_fault
);
    import qdec_pkg::*;

    state_t s_q; // Present state.
    state_t s_d; // Next state.

    // True when the address falls in one of the three channel windows.
    function automatic logic is_ch(input logic [7:0] a);
        is_ch = (a < (CH_STRIDE * 8'h3));
    endfunction : is_ch

    // Next state of the whole block.
    always_comb begin
        logic [2:0] raw;
        logic pa, pb, ea, eb, ei, smp, other, cnt_e, tb, wr, rd, match, same;
        logic [1:0] ch;
        logic [5:0] off;
        logic [FLEN_W-1:0] flen;
        logic [1:0] ns;
        logic decoder_enable, position_enable, speed_enable;
        raw = 3'h0;
        pa = 1'b0;
        pb = 1'b0;
        ea = 1'b0;
        eb = 1'b0;
        ei = 1'b0;
        smp = 1'b0;
        other = 1'b0;
        cnt_e = 1'b0;
        tb = 1'b0;
        match = 1'b0;
        same = 1'b0;
        ns = 2'h0;
        s_d = s_q;
        decoder_enable = s_q.bmr[BMR_DECODER_ENABLE];
        position_enable = s_q.bmr[BMR_POSITION_ENABLE];
        speed_enable = s_q.bmr[BMR_SPEED_ENABLE];
        flen = s_q.bmr[BMR_FLEN_LSB +: FLEN_W];
        ch = i_apb.paddr[7:6];
        off = {i_apb.paddr[5:2], 2'h0};
        // Answer one cycle into the access phase, so every transfer has one wait state.
        s_d.pready = i_apb.psel & i_apb.penable & ~s_q.pready;
        wr = s_d.pready & i_apb.pwrite;
        rd = s_d.pready & ~i_apb.pwrite;

        // Read-to-clear happens first so that an event in the same cycle still sets.
        if (rd && i_apb.paddr == OFF_QISR) begin
            s_d.dirchg = 1'b0;
            s_d.quad_error_flag = 1'b0;
            s_d.idxf = 1'b0;
        end
        if (rd && is_ch(i_apb.paddr) && off == OFF_SR) begin
            s_d.rc_compare_flag[ch] = 1'b0;
        end

        // Polarity and phase definition ahead of the filters.
        pa = i_io_a[0] ^ s_q.bmr[BMR_INVERT_PHASE_A];
        pb = i_io_b[0] ^ s_q.bmr[BMR_INVERT_PHASE_B];
        raw[0] = s_q.bmr[BMR_SWAP] ? pb : pa;
        raw[1] = s_q.bmr[BMR_SWAP] ? pa : pb;
        raw[2] = (s_q.bmr[BMR_INDEX_ON_PHASE_B] ? i_io_b[0] : i_io_a[1]) ^ s_q.bmr[BMR_INVERT_INDEX];

        // A new level must differ for flen+1 cycles before it is passed on.
        for (int i = 0; i < 3; i++) begin
            if (!s_q.bmr[BMR_FILTER]) begin
                s_d.flt[i] = raw[i];
                s_d.fcnt[i] = '0;
            end else if (raw[i] != s_q.flt[i]) begin
                if (s_q.fcnt[i] >= flen) begin
                    s_d.flt[i] = raw[i];
                    s_d.fcnt[i] = '0;
                end else begin
                    s_d.fcnt[i] = s_q.fcnt[i] + 1'b1;
                end
            end else begin
                s_d.fcnt[i] = '0;
            end
        end

        // Edge detection on the filtered lines; no edge is seen while the decoder is off.
        ea = decoder_enable & (s_d.flt[0] != s_q.flt[0]);
        eb = decoder_enable & (s_d.flt[1] != s_q.flt[1]);
        ei = decoder_enable & s_d.flt[2] & ~s_q.flt[2];
        smp = ea ? (s_d.flt[0] ^ s_d.flt[1]) : ~(s_d.flt[0] ^ s_d.flt[1]);
        if (ei) begin
            s_d.idxf = 1'b1;
        end
        if (ea || eb) begin
            s_d.gap = 7'h0;
            other = (ea & s_q.last_b) | (eb & ~s_q.last_b);
            // The gap counter reads k-1 at an edge k cycles after the last one.
            if ((ea && eb) || (other && s_q.gap < {1'b0, flen})) begin
                s_d.quad_error_flag = 1'b1;
            end
            same = (ea & ~eb & ~s_q.last_b) | (eb & ~ea & s_q.last_b);
            s_d.last_b = eb & ~ea;
            if (same) begin
                // Two edges in a row on one phase saw the same other level: arm only.
                s_d.armed = 1'b1;
            end else begin
                if (!s_q.bmr[BMR_DECODE_TRANSPARENT]) begin
                    if (s_q.armed && smp != s_q.dir) begin
                        s_d.dirchg = 1'b1;
                    end
                    s_d.dir = smp;
                end
                s_d.armed = 1'b0;
            end
        end else if (s_q.gap != GAP_MAX) begin
            s_d.gap = s_q.gap + 1'b1;
        end
        cnt_e = ea | (eb & ~s_q.bmr[BMR_EDGPHA]);

        // Channel 2 A line is the speed time base; its rising edge closes a period.
        s_d.tb_prev = s_q.io_a[2];
        tb = decoder_enable & speed_enable & s_q.io_a[2] & ~s_q.tb_prev;

        // Channel counters, compare, Gray stepping and output toggling.
        for (int i = 0; i < 3; i++) begin
            match = s_q.clk_on[i] & (s_q.cv[i] == s_q.rc[i]);
            if (match) begin
                s_d.rc_compare_flag[i] = 1'b1;
            end
            if (s_q.clk_on[i]) begin
                if (decoder_enable && i == 0 && (position_enable || speed_enable)) begin
                    if (ei && position_enable) begin
                        s_d.cv[i] = 16'h0;
                    end else if (cnt_e) begin
                        s_d.cv[i] = s_q.dir ? s_q.cv[i] + 16'h1 : s_q.cv[i] - 16'h1;
                    end
                end else if (decoder_enable && i == 1 && (position_enable || speed_enable)) begin
                    if (ei) begin
                        s_d.cv[i] = s_q.dir ? s_q.cv[i] + 16'h1 : s_q.cv[i] - 16'h1;
                    end
                end else if (s_q.cmr[i][CMR_WAVE] && match) begin
                    s_d.cv[i] = 16'h0;
                end else begin
                    s_d.cv[i] = s_q.cv[i] + 16'h1;
                end
            end
            if (s_q.cmr[i][CMR_WAVE] && match) begin
                if (s_q.smmr[i][SMMR_GRAY_ENABLE]) begin
                    // Step a binary phase counter and drive its Gray image.
                    ns = s_q.smmr[i][SMMR_DOWN] ? s_q.step[i] - 2'h1 : s_q.step[i] + 2'h1;
                    s_d.step[i] = ns;
                    s_d.io_b[i] = ns[1];
                    s_d.io_a[i] = ns[1] ^ ns[0];
                end else if (s_q.cmr[i][CMR_RC_COMPARE_A_ACTION_LSB +: 2] == RC_COMPARE_A_ACTION_TOGGLE) begin
                    s_d.io_a[i] = ~s_q.io_a[i];
                end
            end
        end
        if (tb && s_q.clk_on[0]) begin
            // Capture the edge count of the finished period and restart it.
            s_d.ra[0] = s_q.cv[0];
            // An edge in the capture cycle opens the new period, so no edge is lost.
            s_d.cv[0] = cnt_e ? (s_q.dir ? 16'h1 : 16'hffff) : 16'h0;
        end

        // Register writes; protected registers ignore writes while locked.
        if (wr && is_ch(i_apb.paddr)) begin
            unique case (off)
                OFF_CCR: begin
                    if (i_apb.pwdata[CCR_CLOCK_ENABLE_CMD]) begin
                        s_d.clk_on[ch] = 1'b1;
                    end
                    if (i_apb.pwdata[CCR_CLKDIS]) begin
                        s_d.clk_on[ch] = 1'b0;
                    end
                    if (i_apb.pwdata[CCR_SW_TRIGGER_CMD]) begin
                        s_d.cv[ch] = 16'h0;
                    end
                end
                OFF_CMR: if (!s_q.wpen) s_d.cmr[ch] = i_apb.pwdata;
                OFF_SMMR: if (!s_q.wpen) s_d.smmr[ch] = i_apb.pwdata[1:0];
                OFF_RA: if (!s_q.wpen) s_d.ra[ch] = i_apb.pwdata[15:0];
                OFF_RB: if (!s_q.wpen) s_d.rb[ch] = i_apb.pwdata[15:0];
                OFF_RC: if (!s_q.wpen) s_d.rc[ch] = i_apb.pwdata[15:0];
                default: begin
                end
            endcase
        end else if (wr) begin
            unique case (i_apb.paddr)
                OFF_BMR: if (!s_q.wpen) s_d.bmr = i_apb.pwdata;
                OFF_FMR: if (!s_q.wpen) s_d.fmr = i_apb.pwdata[1:0];
                OFF_WPMR: begin
                    if (i_apb.pwdata[31:8] == PROTECT_KEY) begin
                        s_d.wpen = i_apb.pwdata[0];
                    end
                end
                default: begin
                end
            endcase
        end

        // Read data, registered with the answer.
        s_d.prdata = RESET_WORD;
        s_d.pslverr = 1'b0;
        if (rd && is_ch(i_apb.paddr)) begin
            unique case (off)
                OFF_CMR: s_d.prdata = s_q.cmr[ch];
                OFF_SMMR: s_d.prdata = {30'h0, s_q.smmr[ch]};
                OFF_CV: s_d.prdata = {16'h0, s_q.cv[ch]};
                OFF_RA: s_d.prdata = {16'h0, s_q.ra[ch]};
                OFF_RB: s_d.prdata = {16'h0, s_q.rb[ch]};
                OFF_RC: s_d.prdata = {16'h0, s_q.rc[ch]};
                OFF_SR: s_d.prdata = {27'h0, s_q.rc_compare_flag[ch], 4'h0};
                default: s_d.pslverr = 1'b1;
            endcase
        end else if (rd) begin
            unique case (i_apb.paddr)
                OFF_BMR: s_d.prdata = s_q.bmr;
                OFF_QISR: begin
                    s_d.prdata[QISR_IDX] = s_q.idxf;
                    s_d.prdata[QISR_DIRCHG] = s_q.dirchg;
                    s_d.prdata[QISR_QUAD_ERROR_FLAG] = s_q.quad_error_flag;
                    s_d.prdata[QISR_DIR] = s_q.dir;
                end
                OFF_FMR: s_d.prdata = {30'h0, s_q.fmr};
                OFF_POS: s_d.prdata = {s_q.cv[1], s_q.cv[0]};
                OFF_WPMR: s_d.prdata = {31'h0, s_q.wpen};
                default: s_d.pslverr = 1'b1;
            endcase
        end

        // Fault follows the enabled compare flags of channels 0 and 1.
        s_d.fault = (s_d.rc_compare_flag[0] & s_q.fmr[0]) | (s_d.rc_compare_flag[1] & s_q.fmr[1]);
    end

    // One register for the whole state; reset loads constants only.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_prdata = s_q.prdata;
    assign o_pready = s_q.pready;
    assign o_pslverr = s_q.pslverr;
    assign o_io_a = s_q.io_a;
    assign o_io_b = s_q.io_b;
    assign o_fault = s_q.fault;
endmodule : quadrature_decoder_extensions

// ### src/qdec_pkg.sv
package qdec_pkg;
    // Register byte offsets; channel registers repeat every CH_STRIDE bytes.
    localparam logic [7:0] CH_STRIDE = 8'h40;
    localparam logic [5:0] OFF_CCR = 6'h00;
    localparam logic [5:0] OFF_CMR = 6'h04;
    localparam logic [5:0] OFF_SMMR = 6'h08;
    localparam logic [5:0] OFF_CV = 6'h10;
    localparam logic [5:0] OFF_RA = 6'h14;
    localparam logic [5:0] OFF_RB = 6'h18;
    localparam logic [5:0] OFF_RC = 6'h1c;
    localparam logic [5:0] OFF_SR = 6'h20;
    localparam logic [7:0] OFF_BMR = 8'hc4;
    localparam logic [7:0] OFF_QISR = 8'hd4;
    localparam logic [7:0] OFF_FMR = 8'hd8;
    localparam logic [7:0] OFF_POS = 8'hdc;
    localparam logic [7:0] OFF_WPMR = 8'he4;
    // Block mode register field positions.
    localparam int BMR_DECODER_ENABLE = 8;
    localparam int BMR_POSITION_ENABLE = 9;
    localparam int BMR_SPEED_ENABLE = 10;
    localparam int BMR_DECODE_TRANSPARENT = 11;
    localparam int BMR_EDGPHA = 12;
    localparam int BMR_INVERT_PHASE_A = 13;
    localparam int BMR_INVERT_PHASE_B = 14;
    localparam int BMR_INVERT_INDEX = 15;
    localparam int BMR_SWAP = 16;
    localparam int BMR_INDEX_ON_PHASE_B = 17;
    localparam int BMR_FILTER = 19;
    localparam int BMR_FLEN_LSB = 20;
    localparam int FLEN_W = 6;
    // Channel mode, control, stepper and status field positions.
    localparam int CMR_WAVE = 15;
    localparam int CMR_RC_COMPARE_A_ACTION_LSB = 16;
    localparam logic [1:0] RC_COMPARE_A_ACTION_TOGGLE = 2'h3;
    localparam int CCR_CLOCK_ENABLE_CMD = 0;
    localparam int CCR_CLKDIS = 1;
    localparam int CCR_SW_TRIGGER_CMD = 2;
    localparam int SMMR_GRAY_ENABLE = 0;
    localparam int SMMR_DOWN = 1;
    localparam int SR_RC_COMPARE_FLAG = 4;
    // Quadrature status register field positions.
    localparam int QISR_IDX = 0;
    localparam int QISR_DIRCHG = 1;
    localparam int QISR_QUAD_ERROR_FLAG = 2;
    localparam int QISR_DIR = 8;
    // Write protection key and reset values.
    localparam logic [23:0] PROTECT_KEY = 24'h54494d;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [6:0] GAP_MAX = 7'h7f;

    // APB request from the master.
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    // Whole state of the block, registered as one word.
    typedef struct packed {
        logic [31:0] bmr;
        logic [1:0] fmr;
        logic wpen;
        logic [2:0][31:0] cmr;
        logic [2:0][1:0] smmr;
        logic [2:0][15:0] cv;
        logic [2:0][15:0] ra;
        logic [2:0][15:0] rb;
        logic [2:0][15:0] rc;
        logic [2:0] clk_on;
        logic [2:0] rc_compare_flag;
        logic [2:0] io_a;
        logic [2:0] io_b;
        logic [2:0][1:0] step;
        logic [2:0] flt;
        logic [2:0][FLEN_W-1:0] fcnt;
        logic dir;
        logic dirchg;
        logic quad_error_flag;
        logic idxf;
        logic armed;
        logic last_b;
        logic [6:0] gap;
        logic tb_prev;
        logic fault;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } state_t;
endpackage : qdec_pkg

// ### sim/rotary_sensor_model.sv
`timescale 1ns/1ps
module rotary_sensor_model (
    // Clock.
    input wire logic i_ref_clk,
    // Sensor lines.
    output logic o_pha,
    output logic o_phb,
    output logic o_idx
);
    logic [1:0] pos_q = 2'h0; // Quarter-cycle position of the shaft.
    logic gl_q = 1'b0; // Spurious pulse laid over phase A.
    logic idx_q = 1'b0; // Index pulse, raised only by the pulse task.

    // Position becomes two phase lines a quarter cycle apart.
    assign o_pha = pos_q[0] ^ pos_q[1] ^ gl_q;
    assign o_phb = pos_q[1];
    assign o_idx = idx_q;

    // One quarter step, held for hold cycles; a short hold crowds the phase edges.
    task automatic move(input logic fwd, input int hold);
        pos_q <= fwd ? pos_q + 2'h1 : pos_q - 2'h1;
        repeat (hold) @(posedge i_ref_clk);
    endtask : move

    // Raises phase A noise (which = 0) or the index (which = 1) for len cycles.
    task automatic pulse(input logic which, input int len);
        if (which) idx_q <= 1'b1;
        else gl_q <= 1'b1;
        repeat (len) @(posedge i_ref_clk);
        idx_q <= 1'b0;
        gl_q <= 1'b0;
        repeat (8) @(posedge i_ref_clk);
    endtask : pulse
endmodule : rotary_sensor_model

// ### sim/quadrature_decoder_extensions_chk.sv
`timescale 1ns/1ps
module quadrature_decoder_extensions_chk (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Bus and lines at the block's pins.
    input wire qdec_pkg::apb_req_t i_apb,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic [2:0] i_io_a,
    input wire logic [2:0] i_io_b,
    input wire logic [2:0] o_io_a,
    input wire logic [2:0] o_io_b,
    input wire logic o_fault
);
    import qdec_pkg::*;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    a_one_wait: assert property (i_apb.psel && !i_apb.penable ##1 i_apb.psel && i_apb.penable |=> o_pready)
        else $error("bus answer not one cycle after access");
    a_ready_pulse: assert property (o_pready |=> !o_pready)
        else $error("ready longer than one cycle");
    a_ready_access: assert property (o_pready |-> i_apb.penable && $past(i_apb.penable))
        else $error("ready outside second access cycle");
    a_data_idle: assert property (!o_pready |-> o_prdata == RESET_WORD)
        else $error("read data outside answer");
    a_error_reads: assert property (o_pslverr |-> o_pready && !i_apb.pwrite)
        else $error("error on write or without ready");
    a_error_hole: assert property (o_pready && i_apb.paddr == 8'h0c |-> o_pslverr == !i_apb.pwrite)
        else $error("unmapped read not refused");
    a_gray_one_bit: assert property (!($changed(o_io_a[2]) && $changed(o_io_b[2])))
        else $error("both stepper lines moved at once");
    a_reset_quiet: assert property ($fell(i_rst) |-> !o_pready && !o_fault && o_io_a == 3'h0)
        else $error("outputs active after reset");
    a_fault_clear: assert property ($fell(o_fault) |-> o_pready || $past(o_pready))
        else $error("fault dropped without bus access");

    // Main scenarios seen.
    c_fault: cover property ($rose(o_fault));
    c_error: cover property (o_pslverr);
    c_gray: cover property ($changed(o_io_b[2]));
endmodule : quadrature_decoder_extensions_chk

bind quadrature_decoder_extensions quadrature_decoder_extensions_chk i_chk (.*);

// ### sim/quadrature_decoder_extensions_tb.sv
`timescale 1ns/1ps
module quadrature_decoder_extensions_tb;
    import qdec_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    apb_req_t i_apb = '0;
    logic [31:0] o_prdata;
    logic o_pready, o_pslverr, o_fault;
    logic [2:0] o_io_a, o_io_b;
    logic phase_a, phase_b, idx, up;
    logic [31:0] rnd;
    logic [31:0] rd_q; // Data of the last answer, kept after it has gone.
    int errors = 0;
    int num_checks = 0;
    int n;
    typedef struct {logic [32:0] e; logic [32:0] m;} note_t;
    note_t notes[$]; // Expected answers, oldest first.

    quadrature_decoder_extensions i_quadrature_decoder_extensions (.i_ref_clk(i_ref_clk),
        .i_rst(i_rst), .i_apb(i_apb), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .i_io_a({1'b0, idx, phase_a}), .i_io_b({2'h0, phase_b}),
        .o_io_a(o_io_a), .o_io_b(o_io_b), .o_fault(o_fault));
    rotary_sensor_model i_rotary_sensor_model (.i_ref_clk(i_ref_clk), .o_pha(phase_a),
        .o_phb(phase_b), .o_idx(idx));

    initial forever #2 i_ref_clk = ~i_ref_clk;

    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL %s exp %h got %h", what, exp, seen);
        end
    endtask : check

    // Each answer is judged against the oldest note; answers land at the ready edge.
    always @(posedge i_ref_clk) begin
        if (o_pready === 1'b1 && notes.size() > 0) begin
            check("read data", {o_pslverr, o_prdata} & notes[0].m, notes[0].e);
            rd_q = o_prdata;
            void'(notes.pop_front());
        end
    end

    // One bus transfer; the wait is bounded so a silent slave cannot hang the run.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [32:0] e, input logic [32:0] m);
        notes.push_back('{e, m});
        i_apb <= '{1'b1, 1'b0, w, a, d};
        @(posedge i_ref_clk);
        i_apb.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 50);
        if (n == 50) begin
            errors++;
            complete_run();
        end
        i_apb <= '0;
        @(posedge i_ref_clk);
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 33'h0, 33'h1_0000_0000);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        xfer(1'b0, a, 32'h0, {1'b0, e}, {1'b1, m});
    endtask : rdc

    // Waits for the next stepper change and counts the cycles it took.
    task automatic gray_gap();
        logic [1:0] s;
        s = {o_io_b[2], o_io_a[2]};
        n = 0;
        while ({o_io_b[2], o_io_a[2]} === s && n < 40) begin
            @(posedge i_ref_clk);
            n++;
        end
    endtask : gray_gap

    task automatic complete_run();
        if (errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run

    initial begin
        repeat (20000) @(posedge i_ref_clk);
        errors++;
        complete_run();
    end

    initial begin
        void'($urandom(73));
        repeat (6) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        rdc(OFF_BMR, 32'h0, 32'hffff_ffff);
        xfer(1'b0, 8'h0c, 32'h0, 33'h1_0000_0000, 33'h1_ffff_ffff);
        // Plain counting with the decoder off drives the fault.
        wr(OFF_RC, 32'h20);
        wr(OFF_FMR, 32'h2);
        wr(OFF_CCR, 32'h1);
        repeat (60) @(posedge i_ref_clk);
        check("fault masked", o_fault, 0);
        wr(OFF_FMR, 32'h1);
        repeat (2) @(posedge i_ref_clk);
        check("fault", o_fault, 1);
        rdc(OFF_SR, 32'h10, 32'h10);
        repeat (3) @(posedge i_ref_clk);
        check("fault cleared", o_fault, 0);
        // Position mode, filter off.
        wr(OFF_BMR, 32'h0000_0300);
        wr(OFF_CMR, 32'h0);
        wr(CH_STRIDE + OFF_CMR, 32'h0);
        // Two edges first, so that the direction is settled before counting.
        repeat (2) i_rotary_sensor_model.move(1'b1, 8);
        wr(OFF_CCR, 32'h5);
        wr(CH_STRIDE + OFF_CCR, 32'h5);
        repeat (8) i_rotary_sensor_model.move(1'b1, 8);
        rdc(OFF_QISR, 32'h0, 32'h0);
        up = rd_q[QISR_DIR];
        rdc(OFF_CV, up ? 32'h8 : 32'hfff8, 32'hffff);
        i_rotary_sensor_model.pulse(1'b1, 8);
        rdc(OFF_POS, up ? 32'h0001_0000 : 32'hffff_0000, 32'hffff_ffff);
        // Swapped phases read as the opposite direction.
        wr(OFF_BMR, 32'h0001_0300);
        repeat (2) i_rotary_sensor_model.move(1'b1, 8);
        rdc(OFF_QISR, {23'h0, ~up, 8'h0}, 32'h100);
        i_rotary_sensor_model.move(1'b1, 8);
        rdc(OFF_QISR, 32'h0, 32'h0);
        i_rotary_sensor_model.move(1'b0, 8);
        rdc(OFF_QISR, 32'h0, 32'h2);
        i_rotary_sensor_model.move(1'b0, 8);
        rdc(OFF_QISR, 32'h2, 32'h2);
        rdc(OFF_QISR, 32'h0, 32'h2);
        wr(OFF_BMR, 32'h0001_0b00);
        repeat (2) i_rotary_sensor_model.move(1'b1, 8);
        rdc(OFF_QISR, 32'h0, 32'h2);
        i_rotary_sensor_model.move(1'b1, 8);
        // Filter length 4: a gap of 5 is legal, a gap of 4 is an error.
        wr(OFF_BMR, 32'h0040_0300);
        rdc(OFF_QISR, 32'h0, 32'h0);
        repeat (2) i_rotary_sensor_model.move(1'b1, 5);
        i_rotary_sensor_model.move(1'b1, 8);
        rdc(OFF_QISR, 32'h0, 32'h4);
        i_rotary_sensor_model.move(1'b1, 4);
        i_rotary_sensor_model.move(1'b1, 8);
        rdc(OFF_QISR, 32'h4, 32'h4);
        wr(OFF_BMR, 32'h0048_0300);
        wr(OFF_CCR, 32'h5);
        i_rotary_sensor_model.pulse(1'b0, 4);
        rdc(OFF_CV, 32'h0, 32'hffff);
        i_rotary_sensor_model.move(1'b1, 5);
        i_rotary_sensor_model.move(1'b1, 12);
        rdc(OFF_CV, up ? 32'h2 : 32'hfffe, 32'hffff);
        // Write protection with a wrong and a right key.
        rnd = $urandom;
        rnd[31:8] = (rnd[31:8] == PROTECT_KEY) ? ~rnd[31:8] : rnd[31:8];
        wr(OFF_WPMR, rnd | 32'h1);
        wr(CH_STRIDE + OFF_RC, rnd);
        rdc(CH_STRIDE + OFF_RC, rnd & 32'hffff, 32'hffff);
        wr(OFF_WPMR, {PROTECT_KEY, 8'h01});
        wr(CH_STRIDE + OFF_RC, ~rnd);
        wr(OFF_BMR, 32'h0);
        rdc(CH_STRIDE + OFF_RC, rnd & 32'hffff, 32'hffff);
        rdc(OFF_BMR, 32'h0048_0300, 32'hffff_ffff);
        wr(OFF_WPMR, {PROTECT_KEY, 8'h00});
        wr(OFF_BMR, 32'h0);
        rdc(OFF_BMR, 32'h0, 32'hffff_ffff);
        // Stepper on channel 2, one step per RC + 1 cycles, both directions.
        wr(8'h80 + OFF_CMR, 32'h8000);
        wr(8'h80 + OFF_RC, 32'h3);
        wr(8'h80 + OFF_SMMR, 32'h1);
        wr(8'h80 + OFF_CCR, 32'h5);
        for (int k = 0; k < 2; k++) begin
            gray_gap();
            gray_gap();
            check("gray period", n, 4);
            wr(8'h80 + OFF_SMMR, 32'h3);
        end
        // Speed: channel 2 toggles A every 10 cycles, edges come every 5 cycles.
        wr(8'h80 + OFF_SMMR, 32'h0);
        wr(8'h80 + OFF_RC, 32'h9);
        wr(8'h80 + OFF_CMR, 32'h3_8000);
        wr(OFF_CMR, 32'h0);
        wr(OFF_BMR, 32'h0000_0500);
        wr(OFF_CCR, 32'h5);
        fork
            repeat (20) i_rotary_sensor_model.move(1'b1, 5);
            begin
                repeat (50) @(posedge i_ref_clk);
                rdc(OFF_RA, up ? 32'h4 : 32'hfffc, 32'hffff);
            end
        join
        complete_run();
    end
endmodule : quadrature_decoder_extensions_tb
